// File: pkg/scc_cfg.svh
// register offsets, field positions, reset values and counts of the clock controller
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
// register byte offsets
`define SCC_OFS_CTRL0     8'h00
`define SCC_OFS_CTRL1     8'h04
`define SCC_OFS_CTRL2     8'h08
`define SCC_OFS_CTRL3     8'h0C
`define SCC_OFS_PORT      8'h10
// control zero fields
`define SCC_B_HS_EN       0
`define SCC_B_LS_EN       1
`define SCC_B_HS_REL      2
`define SCC_B_LS_REL      3
`define SCC_B_WU_RUN      4
`define SCC_F_PRCK        9:8
// control one fields
`define SCC_B_SRC_SEL     0
`define SCC_B_SW_STAT     1
`define SCC_B_HALVE       2
`define SCC_B_PERIPHERAL_CLOCK_SOURCE_SELECT       3
`define SCC_F_GEAR        6:4
// control two and three fields
`define SCC_F_WUPT        5:4
`define SCC_B_DRV         7
`define SCC_F_COSEL       5:4
// port fields
`define SCC_B_PDIR        0
`define SCC_B_PFUN        1
// reset values
`define SCC_RST_GEAR      3'h7
`define SCC_RST_WUPT      2'h2
`define SCC_RST_COSEL     2'h1
`define SCC_RST_PRCK      2'h0
// warm-up lengths in oscillator cycles, minus one
`define SCC_WU_LEN1       17'h0_00FF
`define SCC_WU_LEN2       17'h0_3FFF
`define SCC_WU_LEN3       17'h0_FFFF
// prescaler terminal counts: /16, /2, /4, /8
`define SCC_PRE_T0        4'hF
`define SCC_PRE_T1        4'h1
`define SCC_PRE_T2        4'h3
`define SCC_PRE_T3        4'h7
// bus answers
`define SCC_RESP_OKAY     2'h0
`define SCC_RESP_SLVERR   2'h2
`endif

// File: pkg/scc_pkg.sv
// types shared by the clock controller modules
package scc_pkg;
	// software-visible control fields
	typedef struct packed {
		logic       hs_en;
		logic       ls_en;
		logic       hs_rel;
		logic       ls_rel;
		logic [1:0] prck;
		logic       src_sel;
		logic       halve;
		logic       peripheral_clock_source_select;
		logic [2:0] gear;
		logic [1:0] wupt;
		logic       drv;
		logic [1:0] cosel;
		logic       pdir;
		logic       pfun;
	} scc_ctrl_t;
	// clock switch sequencer
	typedef enum logic [1:0] {
		SCC_SW_STEADY = 2'b01,
		SCC_SW_WAIT   = 2'b10
	} scc_sw_t;
endpackage : scc_pkg

// File: rtl/scc_top.sv
// system clock controller: oscillator control, gearing, switch, outputs
// Notes on behaviour
// RULE1: software never changes source select and divider select in one write.
// RULE2: source select writes take effect only while both oscillators are enabled.
// RULE3: software sets stop-release enable of the selected oscillator before stop.
// RULE4: leaving stop always restarts the oscillator the source select chooses.
// RULE5: reset gives high osc on, low osc off, divider 111 (pll clock /8).
// RULE6: pll clock runs at four times the high-speed oscillator rate.
// RULE7: warm-up lasts 2^8, 2^14 or 2^16 oscillator cycles for codes 01,10,11.
// RULE8: writing one starts warm-up; flag reads one while counting, zero after.
// RULE9: warm-up counts cycles of the oscillator being started.
// RULE10: switch status reads one on low-speed clock, zero on geared clock.
// RULE11: source select one picks low-speed clock, zero picks geared clock.
// RULE12: normal to slow: warm low osc, select it, confirm, stop high osc.
// RULE13: slow to normal: warm high osc, select it, confirm, stop low osc.
// RULE14: software stops unsupported peripherals before entering slow mode.
// RULE15: clock out picks geared low, system/2, system, prescaler base clock.
// RULE16: clock out toggles only in normal and slow; held in idle/sleep/stop.
// RULE17: pin is clock out only with direction and function bits both one.
// RULE18: drive reduce resets zero and clears whenever the oscillator restarts.
// RULE19: low-speed halve bit writable only while high-speed clock drives system.
// RULE20: prescaler base is selected peripheral clock divided, /16 after reset.
// RULE21: status changes only once new source drives; no shortened pulses.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "scc_cfg.svh"
module scc_top #(
	parameter int unsigned PLL_MULT = 4,
	parameter int unsigned PER_W    = 16
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// axi4-lite write
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// oscillator ticks and standby state
	input  wire logic        high_osc_tick,
	input  wire logic        low_osc_tick,
	input  wire logic        mode_idle,
	input  wire logic        mode_sleep,
	input  wire logic        mode_stop,
	// oscillator control
	output logic             high_osc_run,
	output logic             low_osc_run,
	output logic             osc_drive_reduce,
	// clock enables
	output logic             system_clock_tick,
	output logic             prescaler_base_tick,
	// clock output pin
	output logic             clock_out_pin,
	output logic             clock_out_oe
);
	generate
		if (PLL_MULT != 4 || PER_W < 4)
		begin : g_chk
			$error("unsupported pll factor or period width");
		end
	endgenerate

	scc_pkg::scc_ctrl_t ctrl_r;
	scc_pkg::scc_sw_t   sw_r;
	logic               aw_hold_r;
	logic               w_hold_r;
	logic [7:0]         waddr_r;
	logic [31:0]        wdata_r;
	logic               wr_fire;
	logic               stop_prev_r;
	logic               stop_exit;
	logic               sleep_prev_r;
	logic               osc_wake;
	logic               active_src_r;
	logic               hi_tick;
	logic               lo_tick;
	logic               wu_busy;
	logic               wu_start;
	logic [PER_W-1:0]   per_cnt_r;
	logic [PER_W-1:0]   per_r;
	logic [PER_W-1:0]   ph_r;
	logic               pll_tick_r;
	logic               pll_emit;
	logic [2:0]         gear_cnt_r;
	logic               gear_tick;
	logic               ls_half_r;
	logic               fsgear_tick;
	logic               sys_tick;
	logic               new_src_tick;
	logic               sys_half_r;
	logic [3:0]         pre_cnt_r;
	logic               fperiph_tick;
	logic               pre_tick;
	logic               cout_tick;
	logic               run_mode;
	logic [31:0]        rd_word;
	logic               wr_c0;
	logic               wr_c1;
	logic               wr_c2;
	logic               wr_c3;
	logic               wr_pt;
	logic               sel_ok;
	logic               halve_ok;

	// prescaler terminal count per divide code
	function automatic logic [3:0] pre_term(input logic [1:0] code);
		case (code)
			2'h1:    pre_term = `SCC_PRE_T1;
			2'h2:    pre_term = `SCC_PRE_T2;
			2'h3:    pre_term = `SCC_PRE_T3;
			default: pre_term = `SCC_PRE_T0;
		endcase
	endfunction : pre_term

	// write side: address and data caught in either order
	assign wr_fire  = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign wr_c0    = wr_fire && (waddr_r == `SCC_OFS_CTRL0) && s_axi_wstrb[0];
	assign wr_c1    = wr_fire && (waddr_r == `SCC_OFS_CTRL1) && s_axi_wstrb[0];
	assign wr_c2    = wr_fire && (waddr_r == `SCC_OFS_CTRL2) && s_axi_wstrb[0];
	assign wr_c3    = wr_fire && (waddr_r == `SCC_OFS_CTRL3) && s_axi_wstrb[0];
	assign wr_pt    = wr_fire && (waddr_r == `SCC_OFS_PORT) && s_axi_wstrb[0];
	assign wu_start = wr_c0 && wdata_r[`SCC_B_WU_RUN];
	// source change needs both oscillators enabled
	assign sel_ok   = ctrl_r.hs_en && ctrl_r.ls_en; // RULE2
	// halving only while the geared clock drives the system
	assign halve_ok = !active_src_r; // RULE19
	assign stop_exit = stop_prev_r && !mode_stop;
	// sleep also parks the high oscillator, so its exit is a restart too
	assign osc_wake = stop_exit || (sleep_prev_r && !mode_sleep);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			aw_hold_r    <= 1'b0;
			w_hold_r     <= 1'b0;
			waddr_r      <= 8'h00;
			wdata_r      <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SCC_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_r <= 1'b1;
				waddr_r   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
			end
			if (wr_fire)
			begin
				aw_hold_r    <= 1'b0;
				w_hold_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (waddr_r > `SCC_OFS_PORT || waddr_r[1:0] != 2'h0)
				                ? `SCC_RESP_SLVERR : `SCC_RESP_OKAY;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ready flops: low while a word is held
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_hold_r && !(s_axi_wvalid && s_axi_wready);
		end
	end

	// control fields; hardware restarts override software writes
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ctrl_r       <= '0;
			ctrl_r.hs_en <= 1'b1; // RULE5
			ctrl_r.gear  <= `SCC_RST_GEAR; // RULE5
			ctrl_r.wupt  <= `SCC_RST_WUPT;
			ctrl_r.cosel <= `SCC_RST_COSEL;
			ctrl_r.prck  <= `SCC_RST_PRCK; // RULE20
			stop_prev_r  <= 1'b0;
			sleep_prev_r <= 1'b0;
		end
		else
		begin
			stop_prev_r <= mode_stop;
			sleep_prev_r <= mode_sleep;
			if (wr_c0)
			begin
				ctrl_r.hs_en  <= wdata_r[`SCC_B_HS_EN];
				ctrl_r.ls_en  <= wdata_r[`SCC_B_LS_EN];
				ctrl_r.hs_rel <= wdata_r[`SCC_B_HS_REL];
				ctrl_r.ls_rel <= wdata_r[`SCC_B_LS_REL];
				ctrl_r.prck   <= wdata_r[`SCC_F_PRCK];
			end
			if (wr_c1)
			begin
				if (sel_ok)
					ctrl_r.src_sel <= wdata_r[`SCC_B_SRC_SEL]; // RULE11
				if (halve_ok)
					ctrl_r.halve <= wdata_r[`SCC_B_HALVE];
				ctrl_r.peripheral_clock_source_select <= wdata_r[`SCC_B_PERIPHERAL_CLOCK_SOURCE_SELECT];
				ctrl_r.gear  <= wdata_r[`SCC_F_GEAR];
			end
			if (wr_c2)
			begin
				ctrl_r.wupt <= wdata_r[`SCC_F_WUPT];
				ctrl_r.drv  <= wdata_r[`SCC_B_DRV];
			end
			if (wr_c3)
				ctrl_r.cosel <= wdata_r[`SCC_F_COSEL];
			if (wr_pt)
			begin
				ctrl_r.pdir <= wdata_r[`SCC_B_PDIR];
				ctrl_r.pfun <= wdata_r[`SCC_B_PFUN];
			end
			// restart of the high oscillator brings back full drive
			if (osc_wake || (wr_c0 && !ctrl_r.hs_en && wdata_r[`SCC_B_HS_EN]))
				ctrl_r.drv <= 1'b0; // RULE18
			// selected oscillator always restarts after stop
			if (stop_exit)
			begin
				ctrl_r.hs_en <= ctrl_r.hs_rel || !ctrl_r.src_sel; // RULE4
				ctrl_r.ls_en <= ctrl_r.ls_rel || ctrl_r.src_sel; // RULE4
			end
		end
	end

	// oscillator run outputs: both stop in stop, high stops in sleep
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			high_osc_run <= 1'b0;
			low_osc_run  <= 1'b0;
		end
		else
		begin
			high_osc_run <= ctrl_r.hs_en && !mode_stop && !mode_sleep;
			low_osc_run  <= ctrl_r.ls_en && !mode_stop;
		end
	end
	assign hi_tick = high_osc_tick && high_osc_run;
	assign lo_tick = low_osc_tick && low_osc_run;

	// warm-up times the oscillator not now driving the system
	scc_warmup u_warmup (
		.clock    (clock),
		.rst      (rst),
		.start    (wu_start), // RULE8
		.osc_tick (active_src_r ? hi_tick : lo_tick), // RULE9
		.time_sel (ctrl_r.wupt),
		.busy     (wu_busy)
	);

	// pll model: measure oscillator period, emit four evenly spaced ticks
	assign pll_emit = hi_tick || (ph_r >= (per_r >> 2) - PER_W'(1));
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			per_cnt_r  <= '0;
			per_r      <= '1;
			ph_r       <= '0;
			pll_tick_r <= 1'b0;
		end
		else if (!high_osc_run)
		begin
			per_cnt_r  <= '0;
			ph_r       <= '0;
			pll_tick_r <= 1'b0;
		end
		else
		begin
			per_cnt_r  <= hi_tick ? '0 : per_cnt_r + PER_W'(1);
			if (hi_tick)
				per_r <= per_cnt_r + PER_W'(1);
			ph_r       <= pll_emit ? '0 : ph_r + PER_W'(1);
			pll_tick_r <= pll_emit; // RULE6
		end
	end

	// gear divider: divide by code plus one, so 111 gives /8
	assign gear_tick = pll_tick_r && (gear_cnt_r >= ctrl_r.gear);
	// low-speed clock optionally halved
	assign fsgear_tick = lo_tick && (!ctrl_r.halve || ls_half_r);
	assign sys_tick = active_src_r ? fsgear_tick : gear_tick; // RULE10
	assign new_src_tick = ctrl_r.src_sel ? fsgear_tick : gear_tick;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			gear_cnt_r <= 3'h0;
			ls_half_r  <= 1'b0;
		end
		else
		begin
			if (pll_tick_r)
				gear_cnt_r <= gear_tick ? 3'h0 : gear_cnt_r + 3'h1; // RULE5
			if (lo_tick)
				ls_half_r <= !ls_half_r;
		end
	end

	// switch waits for a whole tick of the new source, never cuts one
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			sw_r         <= scc_pkg::SCC_SW_STEADY;
			active_src_r <= 1'b0;
		end
		else
		begin
			case (sw_r)
				scc_pkg::SCC_SW_STEADY:
					if (ctrl_r.src_sel != active_src_r)
						sw_r <= scc_pkg::SCC_SW_WAIT;
				scc_pkg::SCC_SW_WAIT:
					if (new_src_tick)
					begin
						active_src_r <= ctrl_r.src_sel; // RULE21
						sw_r         <= scc_pkg::SCC_SW_STEADY;
					end
				default:
					sw_r <= scc_pkg::SCC_SW_STEADY;
			endcase
		end
	end

	// prescaler base from the chosen peripheral clock
	assign fperiph_tick = ctrl_r.peripheral_clock_source_select ? gear_tick : pll_tick_r;
	assign pre_tick = fperiph_tick && (pre_cnt_r >= pre_term(ctrl_r.prck));
	// clock-out source; pin held outside normal and slow
	assign run_mode = !mode_idle && !mode_sleep && !mode_stop;
	assign cout_tick = (ctrl_r.cosel == 2'h0) ? fsgear_tick :
	                   (ctrl_r.cosel == 2'h1) ? (sys_tick && sys_half_r) :
	                   (ctrl_r.cosel == 2'h2) ? sys_tick : pre_tick; // RULE15
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pre_cnt_r           <= 4'h0;
			sys_half_r          <= 1'b0;
			system_clock_tick   <= 1'b0;
			prescaler_base_tick <= 1'b0;
			clock_out_pin       <= 1'b0;
			clock_out_oe        <= 1'b0;
			osc_drive_reduce    <= 1'b0;
		end
		else
		begin
			if (fperiph_tick)
				pre_cnt_r <= pre_tick ? 4'h0 : pre_cnt_r + 4'h1; // RULE20
			if (sys_tick)
				sys_half_r <= !sys_half_r;
			system_clock_tick   <= sys_tick;
			prescaler_base_tick <= pre_tick;
			if (run_mode && cout_tick)
				clock_out_pin <= !clock_out_pin; // RULE16
			clock_out_oe     <= ctrl_r.pdir && ctrl_r.pfun; // RULE17
			osc_drive_reduce <= ctrl_r.drv;
		end
	end

	// read side: one word per aligned offset, others read zero
	assign rd_word =
		(s_axi_araddr == `SCC_OFS_CTRL0) ? {22'h00_0000, ctrl_r.prck, 3'h0,
			wu_busy, ctrl_r.ls_rel, ctrl_r.hs_rel, ctrl_r.ls_en,
			ctrl_r.hs_en} :
		(s_axi_araddr == `SCC_OFS_CTRL1) ? {25'h000_0000, ctrl_r.gear,
			ctrl_r.peripheral_clock_source_select, ctrl_r.halve, active_src_r, ctrl_r.src_sel} :
		(s_axi_araddr == `SCC_OFS_CTRL2) ? {24'h00_0000, ctrl_r.drv, 1'b0,
			ctrl_r.wupt, 4'h0} :
		(s_axi_araddr == `SCC_OFS_CTRL3) ? {26'h000_0000, ctrl_r.cosel,
			4'h0} :
		(s_axi_araddr == `SCC_OFS_PORT) ? {30'h0000_0000, ctrl_r.pfun,
			ctrl_r.pdir} : 32'h0000_0000;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `SCC_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word; // RULE8
				s_axi_rresp  <= (s_axi_araddr > `SCC_OFS_PORT ||
				                 s_axi_araddr[1:0] != 2'h0)
				                ? `SCC_RESP_SLVERR : `SCC_RESP_OKAY;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// checks
	sequence s_stop_leave;
		$fell(mode_stop) ##1 1'b1;
	endsequence
	property p_sel_guard;
		@(posedge clock) disable iff (rst)
		(wr_c1 && !sel_ok) |=> $stable(ctrl_r.src_sel);
	endproperty
	a_sel_guard: assert property (p_sel_guard) // RULE2
		else $error("source select moved with an oscillator off");
	property p_stop_restart;
		@(posedge clock) disable iff (rst)
		s_stop_leave |-> ##1 (ctrl_r.src_sel ? ctrl_r.ls_en : ctrl_r.hs_en);
	endproperty
	a_stop_restart: assert property (p_stop_restart) // RULE4
		else $error("selected oscillator not restarted after stop");
	property p_drive_clear;
		@(posedge clock) disable iff (rst)
		s_stop_leave |-> ##2 !osc_drive_reduce;
	endproperty
	a_drive_clear: assert property (p_drive_clear) // RULE18
		else $error("drive reduce kept after stop release");
	property p_wu_start;
		@(posedge clock) disable iff (rst)
		(wu_start && ctrl_r.wupt != 2'h0) |=> wu_busy;
	endproperty
	a_wu_start: assert property (p_wu_start) // RULE8
		else $error("warm-up did not start");
	property p_switch_clean;
		@(posedge clock) disable iff (rst)
		$changed(active_src_r) |-> $past(new_src_tick) && active_src_r ==
			ctrl_r.src_sel;
	endproperty
	a_switch_clean: assert property (p_switch_clean) // RULE21
		else $error("switch status moved off a new-source tick");
	property p_cout_hold;
		@(posedge clock) disable iff (rst)
		(!run_mode) [*2] |-> $stable(clock_out_pin);
	endproperty
	a_cout_hold: assert property (p_cout_hold) // RULE16
		else $error("clock out toggled in standby");
	property p_pin_enable;
		@(posedge clock) disable iff (rst)
		##1 (clock_out_oe == $past(ctrl_r.pdir && ctrl_r.pfun));
	endproperty
	a_pin_enable: assert property (p_pin_enable) // RULE17
		else $error("clock out enable wrong");
	property p_halve_guard;
		@(posedge clock) disable iff (rst)
		(wr_c1 && active_src_r) |=> $stable(ctrl_r.halve);
	endproperty
	a_halve_guard: assert property (p_halve_guard) // RULE19
		else $error("halve changed while on low-speed clock");
	property p_status_src;
		@(posedge clock) disable iff (rst)
		(sw_r == scc_pkg::SCC_SW_STEADY && $stable(active_src_r)) |->
			sys_tick == (active_src_r ? fsgear_tick : gear_tick);
	endproperty
	a_status_src: assert property (p_status_src) // RULE10
		else $error("system tick not from reported source");
endmodule : scc_top

// File: rtl/scc_warmup.sv
// oscillator warm-up timer counting cycles of the oscillator being started
`timescale 1ns/10ps
`include "scc_cfg.svh"
module scc_warmup #(
	parameter int unsigned CNT_W = 17
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// control
	input  wire logic             start,
	input  wire logic             osc_tick,
	input  wire logic [1:0]       time_sel,
	// status
	output logic                  busy
);
	generate
		if (CNT_W < 17)
		begin : g_chk
			$error("warm-up counter too narrow");
		end
	endgenerate

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] len;
	logic             done;

	// length decode; code 00 means no warm-up
	assign len = (time_sel == 2'h1) ? CNT_W'(`SCC_WU_LEN1) :
	             (time_sel == 2'h2) ? CNT_W'(`SCC_WU_LEN2) :
	                                  CNT_W'(`SCC_WU_LEN3);
	assign done = osc_tick && (cnt_r == len);

	// counts oscillator ticks only, so length tracks its frequency
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			busy  <= 1'b0;
			cnt_r <= '0;
		end
		else if (start)
		begin
			busy  <= (time_sel != 2'h0); // RULE7
			cnt_r <= '0;
		end
		else if (busy && osc_tick)
		begin
			busy  <= !done; // RULE9
			cnt_r <= cnt_r + CNT_W'(1);
		end
	end

	// busy ends after the full count of ticks, or at once on a new start with code 00
	property p_wu_len;
		@(posedge clock) disable iff (rst)
		$fell(busy) |-> $past(done);
	endproperty
	a_wu_len: assert property (p_wu_len) // RULE7
		else $error("warm-up ended before its count");
endmodule : scc_warmup

// File: verification/scc_osc_model.sv
// oscillator tick source standing in for the crystals
`timescale 1ns/10ps
module scc_osc_model #(
	parameter int HI_PER = 8,
	parameter int LO_PER = 10
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// run requests from the controller
	input  wire logic high_osc_run,
	input  wire logic low_osc_run,
	// one pulse per oscillator cycle
	output logic      high_osc_tick,
	output logic      low_osc_tick
);
	int hc_r;
	int lc_r;
	// a stopped oscillator holds still, so no stray ticks leak out
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			hc_r <= 0;
			lc_r <= 0;
		end
		else
		begin
			hc_r <= high_osc_run ? (hc_r + 1) % HI_PER : 0;
			lc_r <= low_osc_run ? (lc_r + 1) % LO_PER : 0;
		end
	end
	// pulse rate tracks the oscillator period, not the bus clock
	assign high_osc_tick = high_osc_run && hc_r == HI_PER - 1;
	assign low_osc_tick  = low_osc_run && lc_r == LO_PER - 1;
endmodule : scc_osc_model

// File: verification/system_clock_controller_tb.sv
// self-checking bench for the system clock controller
`timescale 1ns/10ps
`include "scc_cfg.svh"
module system_clock_controller_tb;
	localparam int HI = 8;
	localparam int LO = 10;
	logic        clock, rst, high_osc_tick, low_osc_tick;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, mode_idle, mode_sleep;
	logic        mode_stop, high_osc_run, low_osc_run, osc_drive_reduce;
	logic        system_clock_tick, prescaler_base_tick;
	logic        clock_out_pin, clock_out_oe;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	int          errors, compares, cyc;

	scc_top u_scc_top (
		.clock, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .high_osc_tick, .low_osc_tick,
		.mode_idle, .mode_sleep, .mode_stop, .high_osc_run, .low_osc_run,
		.osc_drive_reduce, .system_clock_tick, .prescaler_base_tick,
		.clock_out_pin, .clock_out_oe
	);
	scc_osc_model #(.HI_PER(HI), .LO_PER(LO)) u_scc_osc_model (
		.clock, .rst, .high_osc_run, .low_osc_run, .high_osc_tick,
		.low_osc_tick
	);

	// free clock and a cycle stamp for timing warm-up
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) cyc <= cyc + 1;

	task automatic final_report;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [31:0] s, e);
		compares++;
		if (s !== e)
		begin
			errors++;
			$display("ERROR %s exp %h got %h", nm, e, s);
		end
	endtask : chk

	// a bounded wait ran out: count it and stop
	task automatic hang(input string nm);
		chk(nm, 32'h0000_0000, 32'h0000_0001);
		final_report();
	endtask : hang

	// one write; bready held until the answer is seen
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ad, wd;
		int n;
		ad = 0;
		wd = 0;
		@(posedge clock);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge clock);
			if (ad && wd && s_axi_bvalid)
				break;
			ad = ad | s_axi_awready;
			wd = wd | s_axi_wready;
			s_axi_awvalid <= !ad;
			s_axi_wvalid  <= !wd;
		end
		if (n == 100)
			hang("wr");
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		bit ad;
		int n;
		ad = 0;
		@(posedge clock);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge clock);
			if (ad && s_axi_rvalid)
				break;
			ad = ad | s_axi_arready;
			s_axi_arvalid <= !ad;
		end
		if (n == 100)
			hang("rd");
		rd_d = s_axi_rdata;
		rsp  = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic poll(input logic [7:0] a, input logic [31:0] m, e);
		int n;
		for (n = 0; n < 2000; n++)
		begin
			rd(a);
			if ((rd_d & m) === e)
				break;
		end
		if (n == 2000)
			hang("poll");
	endtask : poll

	// count pin edges over c settled samples
	task automatic toggles(input int c, output int t);
		logic last;
		t = 0;
		last = clock_out_pin;
		repeat (c)
		begin
			@(posedge clock);
			#1;
			t += (clock_out_pin !== last);
			last = clock_out_pin;
		end
	endtask : toggles

	// enable, start warm-up, time it in bus cycles against 256 periods of that oscillator
	task automatic warm(input logic [31:0] en, input int per);
		int t0;
		wr(`SCC_OFS_CTRL0, en);
		wr(`SCC_OFS_CTRL0, en | 32'h0000_0010);
		t0 = cyc;
		rd(`SCC_OFS_CTRL0);
		chk("busy", rd_d[4], 1);
		poll(`SCC_OFS_CTRL0, 32'h0000_0010, 32'h0000_0000);
		chk("wu_len", (cyc - t0) inside
			{[256 * per - 20 : 256 * per + 30]}, 1);
	endtask : warm

	// source select alone, divider left as is
	task automatic swap(input logic s);
		wr(`SCC_OFS_CTRL1, 32'h0000_0070 | s);
		poll(`SCC_OFS_CTRL1, 32'h0000_0002, {30'h0, s, 1'b0});
	endtask : swap

	task automatic t_reset;
		chk("hs_run", high_osc_run, 1);
		chk("ls_run", low_osc_run, 0);
		chk("drv", osc_drive_reduce, 0);
		rd(`SCC_OFS_CTRL0);
		chk("ctrl0", rd_d, 32'h0000_0001);
		rd(`SCC_OFS_CTRL1);
		chk("ctrl1", rd_d, 32'h0000_0070);
		rd(8'h14);
		chk("bad_rd", rd_d, 32'h0000_0000);
		chk("bad_rresp", rsp, `SCC_RESP_SLVERR);
		wr(8'h14, 32'h0000_0001);
		chk("bad_wr", rsp, `SCC_RESP_SLVERR);
	endtask : t_reset

	task automatic t_guard;
		wr(`SCC_OFS_CTRL1, 32'h0000_0071);
		rd(`SCC_OFS_CTRL1);
		chk("sel_lock", rd_d, 32'h0000_0070);
		wr(`SCC_OFS_CTRL1, 32'h0000_0074);
		rd(`SCC_OFS_CTRL1);
		chk("halve", rd_d, 32'h0000_0074);
		wr(`SCC_OFS_CTRL1, 32'h0000_0070);
	endtask : t_guard

	// normal to slow and back, with the halve lock in between
	task automatic t_modes;
		wr(`SCC_OFS_CTRL2, 32'h0000_0010);
		warm(32'h0000_0003, LO);
		swap(1'b1);
		wr(`SCC_OFS_CTRL0, 32'h0000_0002);
		repeat (3) @(posedge clock);
		#1;
		chk("hs_off", high_osc_run, 0);
		wr(`SCC_OFS_CTRL1, 32'h0000_0075);
		rd(`SCC_OFS_CTRL1);
		chk("halve_lock", rd_d, 32'h0000_0073);
		warm(32'h0000_0003, HI);
		swap(1'b0);
		wr(`SCC_OFS_CTRL0, 32'h0000_0003);
	endtask : t_modes

	task automatic t_clkout;
		int t[4];
		int x;
		wr(`SCC_OFS_PORT, 32'h0000_0001);
		toggles(3, x);
		chk("oe_off", clock_out_oe, 0);
		wr(`SCC_OFS_PORT, 32'h0000_0003);
		toggles(3, x);
		chk("oe_on", clock_out_oe, 1);
		for (int k = 0; k < 4; k++)
		begin
			wr(`SCC_OFS_CTRL3, k << 4);
			toggles(400, t[k]);
			chk("cout_run", t[k] > 0, 1);
		end
		chk("sys_vs_half", t[2] > t[1], 1);
		chk("sys_rate", t[2] inside {[24:26]}, 1);
		chk("pre_base", (t[2] - 2 * t[3]) inside {[-2:2]}, 1);
		@(posedge clock) mode_idle <= 1'b1;
		toggles(8, x);
		toggles(100, x);
		chk("cout_idle", x, 0);
		@(posedge clock) mode_idle <= 1'b0;
	endtask : t_clkout

	// low drive set, then stop with the selected release bit kept,
	// stop with it cleared (forced restart), and last a sleep
	task automatic t_stop;
		logic [31:0] v;
		logic [1:0]  m;
		for (int p = 0; p < 3; p++)
		begin
			v = (p == 1) ? 32'h0000_000B : 32'h0000_0007;
			m = (p == 2) ? 2'b10 : 2'b01;
			wr(`SCC_OFS_CTRL2, 32'h0000_0090);
			wr(`SCC_OFS_CTRL0, v);
			chk("drv_set", osc_drive_reduce, 1);
			@(posedge clock) {mode_sleep, mode_stop} <= m;
			repeat (10) @(posedge clock);
			{mode_sleep, mode_stop} <= 2'b00;
			repeat (3) @(posedge clock);
			#1;
			chk("restart", high_osc_run, 1);
			chk("ls_release", low_osc_run, p != 0);
			chk("drv_clr", osc_drive_reduce, 0);
		end
	endtask : t_stop

	initial
	begin
		{rst, s_axi_wstrb} = {1'b1, 4'hF};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready} = 2'b00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{mode_idle, mode_sleep, mode_stop} = 3'b000;
		{errors, compares} = {32'd0, 32'd0};
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1;
		t_reset();
		t_guard();
		t_modes();
		t_clkout();
		t_stop();
		final_report();
	end
endmodule : system_clock_controller_tb
